// [common/oad_pkg.sv]
// Types and constants of the operand addressing decoder.
// Assumes a core sequencer that presents one decoded instruction at a time.
package oad_pkg;
  localparam int DATA_W = 8;
  localparam int AMODE_W = 4;
  localparam logic [3:0] LEN_ONE = 4'h1;
  localparam logic [3:0] LEN_TWO = 4'h2;
  localparam logic [3:0] LEN_THREE = 4'h3;
  localparam logic [7:0] PTR_STEP = 8'h01;
  localparam logic [7:0] FLAGS_RESET = 8'h02;

  // Addressing modes presented by the opcode decode
  localparam logic [3:0] AM_SRC_IMM = 4'h0;
  localparam logic [3:0] AM_SRC_DIR = 4'h1;
  localparam logic [3:0] AM_SRC_IDX = 4'h2;
  localparam logic [3:0] AM_DST_DIR = 4'h3;
  localparam logic [3:0] AM_DST_IDX = 4'h4;
  localparam logic [3:0] AM_DST_DIR_IMM = 4'h5;
  localparam logic [3:0] AM_DST_IDX_IMM = 4'h6;
  localparam logic [3:0] AM_MEM_MEM = 4'h7;
  localparam logic [3:0] AM_IND_LOAD = 4'h8;
  localparam logic [3:0] AM_IND_STORE = 4'h9;

  // Core registers selectable by the opcode
  localparam logic [1:0] REG_A = 2'h0;
  localparam logic [1:0] REG_X = 2'h1;
  localparam logic [1:0] REG_F = 2'h2;
  localparam logic [1:0] REG_SP = 2'h3;

  // Operation classes
  localparam logic [1:0] OP_MOVE = 2'h0;
  localparam logic [1:0] OP_ARITH = 2'h1;
  localparam logic [1:0] OP_AND = 2'h2;
  localparam logic [1:0] OP_OR = 2'h3;

  typedef struct packed {
    logic [3:0] mode;
    logic [1:0] reg_sel;
    logic [1:0] op;
    logic [7:0] opnd1;
    logic [7:0] opnd2;
  } oad_instr_s;

  typedef struct packed {
    logic req;
    logic we;
    logic space;
    logic [7:0] addr;
    logic [7:0] wdata;
  } oad_mem_s;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_READ = 6'b00_0010,
    ST_PTR = 6'b00_0100,
    ST_XFER = 6'b00_1000,
    ST_INC = 6'b01_0000,
    ST_DONE = 6'b10_0000
  } oad_state_e;
endpackage : oad_pkg

// [src/oad_addr_gen.sv]
// Effective address former for direct, indexed and pointer addressing.
// Assumes 8-bit address spaces; sums wrap.
module oad_addr_gen (
  input wire logic [7:0] base,
  input wire logic [7:0] index,
  input wire logic use_index,
  output logic [7:0] addr,
  output logic [7:0] base_inc
);
  logic [8:0] sum;
  logic [8:0] inc;

  always_comb
  begin
    sum = {1'b0, base} + {1'b0, (use_index ? index : 8'h00)};
    inc = {1'b0, base} + {1'b0, oad_pkg::PTR_STEP};
    addr = sum[7:0];  // [RULE_13]
    base_inc = inc[7:0];  // [RULE_13]
  end
endmodule : oad_addr_gen

// [src/oad_core_regs.sv]
// Accumulator, index, stack pointer and flags of the core.
// Assumes one write port driven by the decoder sequencer.
module oad_core_regs (
  input wire logic clk,
  input wire logic rst,
  input wire logic we,
  input wire logic [1:0] sel,
  input wire logic [7:0] wdata,
  output logic [7:0] acc,
  output logic [7:0] idx,
  output logic [7:0] sp,
  output logic [7:0] flags
);
  logic [7:0] next_acc;
  logic [7:0] next_idx;
  logic [7:0] next_sp;
  logic [7:0] next_flags;

  always_comb
  begin
    next_acc = acc;
    next_idx = idx;
    next_sp = sp;
    next_flags = flags;
    if (we)
    begin
      case (sel)
        oad_pkg::REG_A: next_acc = wdata;
        oad_pkg::REG_X: next_idx = wdata;
        oad_pkg::REG_SP: next_sp = wdata;
        oad_pkg::REG_F: next_flags = wdata;
        default: next_acc = acc;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      acc <= 8'h00;
      idx <= 8'h00;
      sp <= 8'h00;
      flags <= oad_pkg::FLAGS_RESET;
    end
    else
    begin
      acc <= next_acc;
      idx <= next_idx;
      sp <= next_sp;
      flags <= next_flags;
    end
  end
endmodule : oad_core_regs

// [src/oad_decoder.sv]
// Operand addressing decoder: sequences memory accesses per addressing mode.
// Assumes memory answers a read on the cycle after the request (RD_DATA).
// Notes on behaviour
// RULE_01 - Immediate source writes opcode-selected core register, length two
// RULE_02 - AND immediate into flags combines with flags
// RULE_03 - Direct source reads operand address, length two
// RULE_04 - Indexed source address is operand plus index
// RULE_05 - Arithmetic: memory first source, register second
// RULE_06 - Direct destination writes memory, accumulator kept
// RULE_07 - Indexed destination uses accumulator source only
// RULE_08 - Direct destination immediate source, length three
// RULE_09 - Indexed destination immediate source, length three
// RULE_10 - Memory to memory only for move, three
// RULE_11 - Indirect load into accumulator then pointer increments
// RULE_12 - Indirect store from accumulator then pointer increments
// RULE_13 - Address sums and increments wrap modulo 256
module oad_decoder (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic START,
  input wire oad_pkg::oad_instr_s INSTR,
  input wire logic [7:0] RD_DATA,
  input wire logic [7:0] ALU_RESULT,
  output oad_pkg::oad_mem_s MEM,
  output logic [7:0] ALU_SRC1,
  output logic [7:0] ALU_SRC2,
  output logic [3:0] LENGTH,
  output logic DONE,
  output logic ILLEGAL,
  output logic [7:0] ACC,
  output logic [7:0] IDX,
  output logic [7:0] SP,
  output logic [7:0] FLAGS
);
  oad_pkg::oad_state_e state;
  oad_pkg::oad_state_e next_state;
  oad_pkg::oad_instr_s ins;
  oad_pkg::oad_instr_s next_ins;
  logic [7:0] ptr;
  logic [7:0] next_ptr;
  logic [7:0] src1;
  logic [7:0] next_src1;
  logic [7:0] src2;
  logic [7:0] next_src2;
  logic [3:0] len;
  logic [3:0] next_len;
  logic illegal;
  logic next_illegal;
  oad_pkg::oad_mem_s mem;
  logic reg_we;
  logic [1:0] reg_sel;
  logic [7:0] reg_wdata;
  logic [7:0] acc;
  logic [7:0] idx;
  logic [7:0] sp;
  logic [7:0] flags;
  logic use_index;
  logic [7:0] eff_addr;
  logic [7:0] ptr_inc;
  logic [7:0] sel_reg;
  logic is_move;

  oad_core_regs u_regs (
    .clk(REF_CLK),
    .rst(SYS_RST),
    .we(reg_we),
    .sel(reg_sel),
    .wdata(reg_wdata),
    .acc(acc),
    .idx(idx),
    .sp(sp),
    .flags(flags)
  );

  oad_addr_gen u_addr (
    .base(ins.opnd1),
    .index(idx),
    .use_index(use_index),
    .addr(eff_addr),
    .base_inc(ptr_inc)
  );

  logic [8:0] ptr_sum;
  always_comb
  begin
    ptr_sum = {1'b0, ptr} + {1'b0, oad_pkg::PTR_STEP};
  end

  always_comb
  begin
    use_index = (ins.mode == oad_pkg::AM_SRC_IDX) || (ins.mode == oad_pkg::AM_DST_IDX)
      || (ins.mode == oad_pkg::AM_DST_IDX_IMM);  // [RULE_04] [RULE_07] [RULE_09]
    is_move = (ins.op == oad_pkg::OP_MOVE);
    // In idle the mux looks at the incoming opcode so sources can be preloaded
    case ((state == oad_pkg::ST_IDLE) ? INSTR.reg_sel : ins.reg_sel)
      oad_pkg::REG_X: sel_reg = idx;
      oad_pkg::REG_F: sel_reg = flags;
      oad_pkg::REG_SP: sel_reg = sp;
      default: sel_reg = acc;
    endcase
  end

  always_comb
  begin
    next_state = state;
    next_ins = ins;
    next_ptr = ptr;
    next_src1 = src1;
    next_src2 = src2;
    next_len = len;
    next_illegal = illegal;
    mem = '0;
    reg_we = 1'b0;
    reg_sel = ins.reg_sel;
    reg_wdata = 8'h00;
    case (state)
      oad_pkg::ST_IDLE:
      begin
        if (START)
        begin
          next_ins = INSTR;
          next_src1 = INSTR.opnd1;  // [RULE_01]
          next_src2 = sel_reg;  // [RULE_05]
          next_illegal = 1'b0;
          next_state = oad_pkg::ST_READ;
          case (INSTR.mode)
            oad_pkg::AM_SRC_IMM, oad_pkg::AM_SRC_DIR, oad_pkg::AM_SRC_IDX,
            oad_pkg::AM_DST_DIR, oad_pkg::AM_DST_IDX:
              next_len = oad_pkg::LEN_TWO;  // [RULE_01] [RULE_03] [RULE_04] [RULE_06] [RULE_07]
            oad_pkg::AM_DST_DIR_IMM, oad_pkg::AM_DST_IDX_IMM:
              next_len = oad_pkg::LEN_THREE;  // [RULE_08] [RULE_09]
            oad_pkg::AM_MEM_MEM:
            begin
              next_len = oad_pkg::LEN_THREE;  // [RULE_10]
              next_illegal = INSTR.op != oad_pkg::OP_MOVE;
            end
            oad_pkg::AM_IND_LOAD, oad_pkg::AM_IND_STORE:
            begin
              next_len = oad_pkg::LEN_TWO;  // [RULE_11] [RULE_12]
              next_illegal = INSTR.op != oad_pkg::OP_MOVE;
            end
            default:
            begin
              next_len = oad_pkg::LEN_ONE;
              next_illegal = 1'b1;
            end
          endcase
        end
      end
      oad_pkg::ST_READ:
      begin
        // Issue the operand read; immediate source, destination move and illegal cases skip it
        if (illegal)
          next_state = oad_pkg::ST_DONE;
        else
        begin
          case (ins.mode)
            oad_pkg::AM_SRC_IMM:
            begin
              reg_we = 1'b1;  // [RULE_01]
              if (ins.reg_sel == oad_pkg::REG_F && ins.op == oad_pkg::OP_AND)
                reg_wdata = flags & ins.opnd1;  // [RULE_02]
              else if (ins.op == oad_pkg::OP_OR)
                reg_wdata = sel_reg | ins.opnd1;
              else if (ins.op == oad_pkg::OP_AND)
                reg_wdata = sel_reg & ins.opnd1;
              else if (ins.op == oad_pkg::OP_ARITH)
                reg_wdata = ALU_RESULT;
              else
                reg_wdata = ins.opnd1;
              next_src1 = ins.opnd1;
              next_src2 = sel_reg;
              next_state = oad_pkg::ST_DONE;
            end
            oad_pkg::AM_DST_DIR, oad_pkg::AM_DST_IDX:
            begin
              // Indexed destination always sources the accumulator
              next_src2 = (ins.mode == oad_pkg::AM_DST_IDX) ? acc : sel_reg;  // [RULE_06] [RULE_07]
              mem.req = ~is_move;
              mem.addr = eff_addr;
              next_state = oad_pkg::ST_XFER;
            end
            oad_pkg::AM_DST_DIR_IMM, oad_pkg::AM_DST_IDX_IMM:
            begin
              next_src2 = ins.opnd2;  // [RULE_08] [RULE_09]
              mem.req = ~is_move;
              mem.addr = eff_addr;
              next_state = oad_pkg::ST_XFER;
            end
            oad_pkg::AM_MEM_MEM:
            begin
              mem.req = 1'b1;
              mem.addr = ins.opnd2;  // [RULE_10]
              next_state = oad_pkg::ST_XFER;
            end
            oad_pkg::AM_IND_LOAD, oad_pkg::AM_IND_STORE:
            begin
              mem.req = 1'b1;
              mem.addr = ins.opnd1;  // [RULE_11] [RULE_12]
              next_state = oad_pkg::ST_PTR;
            end
            default:
            begin
              mem.req = 1'b1;
              mem.addr = eff_addr;  // [RULE_03] [RULE_04]
              next_state = oad_pkg::ST_XFER;
            end
          endcase
        end
      end
      oad_pkg::ST_PTR:
      begin
        next_ptr = RD_DATA;
        mem.req = 1'b1;
        mem.addr = RD_DATA;
        mem.we = ins.mode == oad_pkg::AM_IND_STORE;
        mem.wdata = acc;  // [RULE_12]
        next_state = oad_pkg::ST_XFER;
      end
      oad_pkg::ST_XFER:
      begin
        case (ins.mode)
          oad_pkg::AM_SRC_DIR, oad_pkg::AM_SRC_IDX:
          begin
            next_src1 = RD_DATA;  // [RULE_05]
            next_src2 = sel_reg;  // [RULE_05]
            reg_we = 1'b1;
            reg_wdata = is_move ? RD_DATA : ALU_RESULT;  // [RULE_03]
            next_state = oad_pkg::ST_DONE;
          end
          oad_pkg::AM_MEM_MEM:
          begin
            mem.req = 1'b1;
            mem.we = 1'b1;
            mem.addr = ins.opnd1;
            mem.wdata = RD_DATA;  // [RULE_10]
            next_state = oad_pkg::ST_DONE;
          end
          oad_pkg::AM_IND_LOAD, oad_pkg::AM_IND_STORE:
          begin
            if (ins.mode == oad_pkg::AM_IND_LOAD)
            begin
              reg_we = 1'b1;
              reg_sel = oad_pkg::REG_A;
              reg_wdata = RD_DATA;  // [RULE_11]
            end
            next_state = oad_pkg::ST_INC;
          end
          default:
          begin
            // Destination modes: memory operand is the first source
            next_src1 = RD_DATA;
            mem.req = 1'b1;
            mem.we = 1'b1;
            mem.addr = eff_addr;  // [RULE_06] [RULE_07] [RULE_08] [RULE_09]
            mem.wdata = is_move ? src2 : ALU_RESULT;
            next_state = oad_pkg::ST_DONE;
          end
        endcase
      end
      oad_pkg::ST_INC:
      begin
        mem.req = 1'b1;
        mem.we = 1'b1;
        mem.addr = ins.opnd1;
        mem.wdata = ptr_sum[7:0];  // [RULE_11] [RULE_12] [RULE_13]
        next_state = oad_pkg::ST_DONE;
      end
      oad_pkg::ST_DONE:
        next_state = oad_pkg::ST_IDLE;
      default:
        next_state = oad_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      state <= oad_pkg::ST_IDLE;
      ins <= '0;
      ptr <= 8'h00;
      src1 <= 8'h00;
      src2 <= 8'h00;
      len <= 4'h0;
      illegal <= 1'b0;
    end
    else
    begin
      state <= next_state;
      ins <= next_ins;
      ptr <= next_ptr;
      src1 <= next_src1;
      src2 <= next_src2;
      len <= next_len;
      illegal <= next_illegal;
    end
  end

  // Memory space bit: opcode selects RAM (0) or register space (1); memory-to-memory and indirect modes always use RAM
  always_comb
  begin
    MEM = mem;
    MEM.space = ins.reg_sel[1] & ~(ins.mode inside {oad_pkg::AM_MEM_MEM, oad_pkg::AM_IND_LOAD,
      oad_pkg::AM_IND_STORE});
  end

  assign ALU_SRC1 = (state == oad_pkg::ST_XFER) ? RD_DATA : src1;
  assign ALU_SRC2 = src2;
  assign LENGTH = len;
  assign DONE = state == oad_pkg::ST_DONE;
  assign ILLEGAL = illegal & DONE;
  assign ACC = acc;
  assign IDX = idx;
  assign SP = sp;
  assign FLAGS = flags;

  a_len_three: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    DONE && !illegal && ins.mode == oad_pkg::AM_DST_DIR_IMM |-> LENGTH == 4'h3)  // [RULE_08]
    else $error("direct destination immediate length not three");
  a_len_two: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    DONE && ins.mode == oad_pkg::AM_SRC_DIR |-> LENGTH == 4'h2)  // [RULE_03]
    else $error("direct source length not two");
  a_flag_and: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    state == oad_pkg::ST_READ && !illegal && ins.mode == oad_pkg::AM_SRC_IMM && ins.reg_sel == oad_pkg::REG_F
    && ins.op == oad_pkg::OP_AND |=> FLAGS == ($past(FLAGS) & $past(ins.opnd1)))  // [RULE_02]
    else $error("flags AND result wrong");
  a_idx_addr: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    state == oad_pkg::ST_READ && !illegal && ins.mode == oad_pkg::AM_SRC_IDX
    |-> MEM.req && MEM.addr == 8'(ins.opnd1 + idx))  // [RULE_04]
    else $error("indexed source address wrong");
  a_dst_acc: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    state == oad_pkg::ST_READ && !illegal && ins.mode == oad_pkg::AM_DST_DIR |=> ##1 ACC == $past(ACC, 2))  // [RULE_06]
    else $error("accumulator changed by direct destination");
  a_mm_copy: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    state == oad_pkg::ST_READ && !illegal && ins.mode == oad_pkg::AM_MEM_MEM
    |=> MEM.we && MEM.addr == ins.opnd1 && MEM.wdata == RD_DATA)  // [RULE_10]
    else $error("memory copy write wrong");
  a_ptr_inc: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    state == oad_pkg::ST_PTR |=> ##1 MEM.we && MEM.wdata == 8'($past(RD_DATA, 2) + 8'h01))  // [RULE_11] [RULE_13]
    else $error("pointer not incremented");
  a_ind_store: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    state == oad_pkg::ST_PTR && ins.mode == oad_pkg::AM_IND_STORE |-> MEM.we && MEM.wdata == ACC)  // [RULE_12]
    else $error("indirect store data wrong");
  a_mm_move: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    DONE && ins.mode == oad_pkg::AM_MEM_MEM && ins.op != oad_pkg::OP_MOVE |-> ILLEGAL)  // [RULE_10]
    else $error("memory copy accepted for non-move");
  c_ind_load: cover property (@(posedge REF_CLK) state == oad_pkg::ST_INC && ins.mode == oad_pkg::AM_IND_LOAD);
  c_mem_mem: cover property (@(posedge REF_CLK) DONE && ins.mode == oad_pkg::AM_MEM_MEM && !illegal);
  c_dst_idx: cover property (@(posedge REF_CLK) DONE && ins.mode == oad_pkg::AM_DST_IDX_IMM);
endmodule : oad_decoder

// [sim/oad_mem_model.sv]
// Data RAM and register space seen from the decoder's memory port.
// Assumes one request per cycle; read data follows a read by one cycle.
module oad_mem_model (
  input wire logic clk,
  input wire oad_pkg::oad_mem_s bus,
  output logic [7:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] mem [0:511];

  initial rd_data = 8'h00;

  // Outside a read the line toggles, so stale data never passes for fresh
  always @(posedge clk)
  begin
    if (bus.req && bus.we)
    begin
      mem[{bus.space, bus.addr}] <= bus.wdata;
    end
    if (bus.req && !bus.we)
    begin
      rd_data <= mem[{bus.space, bus.addr}];
    end
    else
    begin
      rd_data <= ~rd_data;
    end
  end
endmodule : oad_mem_model

// [sim/tb_top.sv]
// Self-checking bench for the operand addressing decoder.
// Assumes the memory model above and an ALU formed here from the op class.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic REF_CLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic START = 1'b0;
  oad_pkg::oad_instr_s INSTR = '0;
  wire logic [7:0] RD_DATA;
  logic [7:0] ALU_RESULT;
  oad_pkg::oad_mem_s MEM;
  logic [7:0] ALU_SRC1, ALU_SRC2, ACC, IDX, SP, FLAGS;
  logic [3:0] LENGTH;
  logic DONE, ILLEGAL;
  int miscompares = 0;
  int checks_done = 0;
  int nreq = 0;
  int mdl [0:511];
  int rg [0:3];
  logic [16:0] wq [$];
  logic [16:0] ew [$];
  logic [31:0] lfsr = 32'h0000_8b11;
  logic [3:0] modes [0:10] = '{oad_pkg::AM_SRC_IMM, oad_pkg::AM_SRC_DIR, oad_pkg::AM_SRC_IDX,
    oad_pkg::AM_DST_DIR, oad_pkg::AM_DST_IDX, oad_pkg::AM_DST_DIR_IMM, oad_pkg::AM_DST_IDX_IMM,
    oad_pkg::AM_MEM_MEM, oad_pkg::AM_IND_LOAD, oad_pkg::AM_IND_STORE, 4'hc};

  always #2.5 REF_CLK = ~REF_CLK;

  oad_decoder u_dut (
    .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .START(START), .INSTR(INSTR), .RD_DATA(RD_DATA),
    .ALU_RESULT(ALU_RESULT), .MEM(MEM), .ALU_SRC1(ALU_SRC1), .ALU_SRC2(ALU_SRC2), .LENGTH(LENGTH),
    .DONE(DONE), .ILLEGAL(ILLEGAL), .ACC(ACC), .IDX(IDX), .SP(SP), .FLAGS(FLAGS)
  );

  oad_mem_model u_mem (
    .clk(REF_CLK),
    .bus(MEM),
    .rd_data(RD_DATA)
  );

  function automatic int alu(input logic [1:0] op, input int a, input int b);
    case (op)
      oad_pkg::OP_ARITH: return (a + b) % 256;
      oad_pkg::OP_AND: return a & b;
      oad_pkg::OP_OR: return a | b;
      default: return a;
    endcase
  endfunction : alu

  always_comb ALU_RESULT = 8'(alu(INSTR.op, ALU_SRC1, ALU_SRC2));

  function automatic logic [7:0] rnd();
    repeat (8) lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction : rnd

  function automatic void wr(input int a, input int d);
    ew.push_back({1'b0, 8'(a), 8'(d)});
    mdl[a] = d;
  endfunction : wr

  always @(posedge REF_CLK)
  begin
    if (!SYS_RST && MEM.req)
    begin
      nreq++;
      if (MEM.we)
      begin
        wq.push_back({MEM.space, MEM.addr, MEM.wdata});
      end
    end
  end

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
    begin
      $display("No errors found");
    end
    else
    begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up

  // Entered just after an edge in idle; returns just after the edge that leaves DONE
  task automatic exec(input logic [3:0] md, input logic [1:0] sel, input logic [1:0] op,
    input logic [7:0] o1, input logic [7:0] o2);
    int a;
    int p;
    int k;
    logic ill;
    logic [3:0] len;
    ill = 1'b0;
    len = oad_pkg::LEN_TWO;
    ew.delete();
    case (md)
      oad_pkg::AM_SRC_IMM: rg[sel] = alu(op, o1, rg[sel]);
      oad_pkg::AM_SRC_DIR, oad_pkg::AM_SRC_IDX:
      begin
        a = (md == oad_pkg::AM_SRC_DIR) ? o1 : (o1 + rg[1]) % 256;
        rg[sel] = alu(op, mdl[a], rg[sel]);
      end
      oad_pkg::AM_DST_DIR, oad_pkg::AM_DST_IDX:
      begin
        a = (md == oad_pkg::AM_DST_DIR) ? o1 : (o1 + rg[1]) % 256;
        p = (md == oad_pkg::AM_DST_DIR) ? rg[sel] : rg[0];
        wr(a, (op == oad_pkg::OP_MOVE) ? p : alu(op, mdl[a], p));
      end
      oad_pkg::AM_DST_DIR_IMM, oad_pkg::AM_DST_IDX_IMM:
      begin
        a = (md == oad_pkg::AM_DST_DIR_IMM) ? o1 : (o1 + rg[1]) % 256;
        wr(a, alu(op, o2, mdl[a]));
        len = oad_pkg::LEN_THREE;
      end
      oad_pkg::AM_MEM_MEM:
      begin
        ill = (op != oad_pkg::OP_MOVE);
        len = oad_pkg::LEN_THREE;
        if (!ill) wr(o1, mdl[o2]);
      end
      oad_pkg::AM_IND_LOAD, oad_pkg::AM_IND_STORE:
      begin
        ill = (op != oad_pkg::OP_MOVE);
        p = mdl[o1];
        if (!ill && md == oad_pkg::AM_IND_LOAD) rg[0] = mdl[p];
        if (!ill && md == oad_pkg::AM_IND_STORE) wr(p, rg[0]);
        if (!ill) wr(o1, (p + 1) % 256);
      end
      default: ill = 1'b1;
    endcase
    wq.delete();
    nreq = 0;
    INSTR = '{mode: md, reg_sel: sel, op: op, opnd1: o1, opnd2: o2};
    START = 1'b1;
    @(posedge REF_CLK);
    #1 START = 1'b0;
    for (k = 0; k < 20 && DONE !== 1'b1; k++)
    begin
      @(posedge REF_CLK);
      #1;
    end
    if (DONE !== 1'b1)
    begin
      miscompares++;
      wrap_up();
    end
    check(ILLEGAL, ill);
    if (ill) check(nreq, 0);
    else check(LENGTH, len);
    check({ACC, IDX, FLAGS, SP}, {8'(rg[0]), 8'(rg[1]), 8'(rg[2]), 8'(rg[3])});
    check(wq.size(), ew.size());
    foreach (ew[i]) check(wq[i], ew[i]);
    // START is only taken in idle, one edge after DONE
    @(posedge REF_CLK);
    #1;
  endtask : exec

  initial
  begin
    logic [7:0] t;
    logic [3:0] md;
    logic [1:0] op;
    for (int i = 0; i < 512; i++)
    begin
      t = rnd();
      u_mem.mem[i] = t;
      mdl[i] = t;
    end
    rg = '{0, 0, int'(oad_pkg::FLAGS_RESET), 0};
    repeat (6) @(posedge REF_CLK);
    #1 SYS_RST = 1'b0;
    check({ACC, IDX, SP, FLAGS, DONE, MEM.req}, {24'h00_0000, oad_pkg::FLAGS_RESET, 2'b00});
    $display("Test reset values done");
    exec(oad_pkg::AM_SRC_IMM, oad_pkg::REG_X, oad_pkg::OP_MOVE, 8'hf3, 8'h00);
    exec(oad_pkg::AM_SRC_IMM, oad_pkg::REG_A, oad_pkg::OP_MOVE, 8'h5c, 8'h00);
    exec(oad_pkg::AM_SRC_IMM, oad_pkg::REG_F, oad_pkg::OP_OR, 8'h0f, 8'h00);
    exec(oad_pkg::AM_SRC_IMM, oad_pkg::REG_F, oad_pkg::OP_AND, 8'h0a, 8'h00);
    exec(oad_pkg::AM_SRC_IMM, oad_pkg::REG_SP, oad_pkg::OP_ARITH, 8'h10, 8'h00);
    $display("Test immediate sources done");
    // Pointer at the top of the space must roll over to zero
    exec(oad_pkg::AM_DST_DIR_IMM, oad_pkg::REG_A, oad_pkg::OP_MOVE, 8'h40, 8'hff);
    exec(oad_pkg::AM_IND_LOAD, oad_pkg::REG_A, oad_pkg::OP_MOVE, 8'h40, 8'h00);
    exec(oad_pkg::AM_IND_STORE, oad_pkg::REG_A, oad_pkg::OP_MOVE, 8'h40, 8'h00);
    $display("Test pointer wrap done");
    for (int n = 0; n < 120; n++)
    begin
      md = modes[rnd() % 11];
      op = 2'(rnd());
      t = rnd();
      exec(md, {md == oad_pkg::AM_SRC_IMM && t[1], t[0]}, op, rnd(), rnd());
    end
    $display("Test random modes done");
    wrap_up();
  end
endmodule : tb_top
